// >>> dv/i2c_ctl_model.sv
// i2c bus controller model for the expander bench
`timescale 1ns/100ps
module i2c_ctl_model (
    // clock
    input  wire logic i_clk,
    // bus
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda_low
);
    initial begin
        o_scl     = 1'b1;
        o_sda_low = 1'b0;
    end
    // hold one bus level for n core cycles; sda never moves together with an scl edge
    task automatic lvl(input logic scl, input logic low, input int n);
        @(posedge i_clk);
        o_scl     <= scl;
        o_sda_low <= low;
        repeat (n - 1) @(posedge i_clk);
    endtask : lvl
    task automatic bit_io(input logic b, output logic r);
        lvl(1'b0, o_sda_low, 2);
        lvl(1'b0, ~b, 2);
        lvl(1'b1, ~b, 4);
        r = i_sda;
    endtask : bit_io
    task automatic start(input logic rep);
        if (rep) begin
            lvl(1'b0, o_sda_low, 2);
            lvl(1'b0, 1'b0, 2);
            lvl(1'b1, 1'b0, 4);
        end
        lvl(1'b1, 1'b1, 4);
    endtask : start
    task automatic stop();
        lvl(1'b0, o_sda_low, 2);
        lvl(1'b0, 1'b1, 2);
        lvl(1'b1, 1'b1, 4);
        lvl(1'b1, 1'b0, 4);
    endtask : stop
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask : wr_byte
    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(last, r);
    endtask : rd_byte
endmodule : i2c_ctl_model

// >>> dv/i2c_forty_bit_io_expander_bench.sv
// self-checking bench of the forty-line i2c expander
`timescale 1ns/100ps
`include "gpio_exp_regs.svh"
module i2c_forty_bit_io_expander_bench;
    localparam logic [39:0] ID = 40'h00_0001_3c5a; // arbitrary identity bytes
    logic        clk;
    logic        reset_n;
    logic        rst_pin_n;
    logic        oe_n;
    logic [5:0]  asel;
    logic [6:0]  own;
    logic [39:0] ext;
    logic [39:0] out;
    logic [39:0] old;
    logic [39:0] dir;
    logic [39:0] od;
    logic [39:0] pol;
    logic [39:0] v;
    logic [39:0] io;
    logic [39:0] io_oe_n;
    logic        sda_oe_n;
    logic        scl;
    logic        sda_low;
    logic        int_oe_n;
    logic        alert_oe_n;
    integer      seed;
    int          errors;
    int          check_count;
    wire logic        sda   = sda_oe_n & ~sda_low;
    wire logic [39:0] io_in = (io_oe_n & ext) | (~io_oe_n & io);
    ////////////////////////////////////////////////////////////////////////
    gpio_expander #(.ID_MFR(ID[7:0]), .ID_PART(ID[15:8]), .ID_REV(ID[23:16])) DUT (
        .I_CLK(clk), .I_RESET_N(reset_n), .I_SCL(scl), .I_SDA(sda), .O_SDA_OE_N(sda_oe_n),
        .I_RST_PIN_N(rst_pin_n), .I_OE_N(oe_n), .I_ASEL(asel), .I_IO(io_in), .O_IO(io),
        .O_IO_OE_N(io_oe_n), .O_INT_OE_N(int_oe_n), .O_ALERT_OE_N(alert_oe_n));
    i2c_ctl_model ctl (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [39:0] rnd40();
        logic [63:0] r;
        r = {$random(seed), $random(seed)};
        return r[39:0];
    endfunction : rnd40
    function automatic logic [39:0] exp_oe_n(input logic [39:0] d, o, u);
        return oe_n ? '1 : (d | (o & u));
    endfunction : exp_oe_n
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic stop_test();
        if (errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test
    // only this address goes unanswered; every other one used here must be acked
    task automatic wr_regs(input logic [6:0] a, input logic [7:0] p, input int n, input logic [39:0] d,
                           input logic stp);
        logic ack;
        ctl.start(1'b0);
        ctl.wr_byte({a, 1'b0}, ack);
        chk({39'h0, ack}, {39'h0, a != 7'h10});
        ctl.wr_byte(p, ack);
        for (int i = 0; i < n; i++) ctl.wr_byte(d[8*i+:8], ack);
        if (stp) ctl.stop();
    endtask : wr_regs
    task automatic rd_regs(input logic [7:0] p, input int n, output logic [39:0] d);
        logic ack;
        d = '0;
        ctl.start(1'b0);
        ctl.wr_byte({own, 1'b0}, ack);
        ctl.wr_byte(p, ack);
        ctl.start(1'b1);
        ctl.wr_byte({own, 1'b1}, ack);
        for (int i = 0; i < n; i++) ctl.rd_byte(i == n - 1, d[8*i+:8]);
        ctl.stop();
    endtask : rd_regs
    task automatic chk_lines();
        repeat (8) @(posedge clk);
        chk(io_oe_n, exp_oe_n(dir, od, out));
        chk(io & ~io_oe_n, out & ~od & ~io_oe_n);
    endtask : chk_lines
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        stop_test();
    end
    initial begin
        seed = 32'hf3a4259b;
        errors = 0;
        check_count = 0;
        reset_n = 1'b0;
        rst_pin_n = 1'b1;
        oe_n = 1'b0;
        ext = rnd40();
        asel = ext[5:0];
        own = `TGT_BASE + {1'b0, asel};
        od = '0;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        repeat (8) @(posedge clk);
        chk(io_oe_n, '1);
        rd_regs(8'h38, 3, v);
        chk(v, ID);
        out = rnd40();
        wr_regs(own, 8'h08, 5, out, 1'b1);
        dir = rnd40();
        wr_regs(own, 8'h18, 5, dir, 1'b0);
        chk_lines();
        ctl.stop();
        od = rnd40();
        wr_regs(own, 8'h28, 5, od, 1'b1);
        chk_lines();
        rd_regs(8'h18, 5, v);
        chk(v, dir);
        rd_regs(8'h28, 5, v);
        chk(v, od);
        @(posedge clk);
        oe_n <= 1'b1;
        chk_lines();
        @(posedge clk);
        oe_n <= 1'b0;
        chk_lines();
        wr_regs(own, 8'h30, 1, 40'h01, 1'b1);
        old = out;
        out = rnd40();
        wr_regs(`ALLCALL_ADR, 8'h08, 5, out, 1'b0);
        chk(io_oe_n, exp_oe_n(dir, od, old));
        ctl.stop();
        chk_lines();
        wr_regs(7'h10, 8'h08, 5, ~out, 1'b1);
        chk_lines();
        @(posedge clk);
        rst_pin_n <= 1'b0;
        repeat (8) @(posedge clk);
        chk(io_oe_n, '1);
        rst_pin_n <= 1'b1;
        repeat (8) @(posedge clk);
        wr_regs(own, 8'h30, 1, 40'h02, 1'b1);
        pol = rnd40();
        wr_regs(own, 8'h10, 5, pol, 1'b1);
        wr_regs(own, 8'h20, 5, 40'hff, 1'b1);
        ext <= rnd40();
        repeat (8) @(posedge clk);
        rd_regs(8'h00, 5, v);
        chk(v, ext ^ pol);
        repeat (4) @(posedge clk);
        chk({39'h0, int_oe_n}, 40'h1);
        chk({39'h0, alert_oe_n}, 40'h0);
        ctl.start(1'b0);
        ctl.wr_byte({`ARA_ADR, 1'b1}, v[8]);
        ctl.rd_byte(1'b1, v[7:0]);
        ctl.stop();
        chk({31'h0, v[8:0]}, {31'h0, 1'b1, own, 1'b0});
        chk({39'h0, alert_oe_n}, 40'h1);
        ctl.start(1'b0);
        ctl.wr_byte({`ALLCALL_ADR, 1'b1}, v[9]);
        ctl.stop();
        chk({39'h0, v[9]}, 40'h0);
        ext[7:0] <= ~ext[7:0];
        repeat (12) @(posedge clk);
        chk({39'h0, int_oe_n}, 40'h1);
        ext[23:16] <= ~ext[23:16];
        for (int n = 0; int_oe_n !== 1'b0; n++) begin
            @(posedge clk);
            if (n == 20) begin
                errors++;
                stop_test();
            end
        end
        chk({39'h0, int_oe_n}, 40'h0);
        rd_regs(8'h02, 1, v);
        chk({32'h0, v[7:0]}, {32'h0, ext[23:16] ^ pol[23:16]});
        repeat (4) @(posedge clk);
        chk({39'h0, int_oe_n}, 40'h1);
        stop_test();
    end
endmodule : i2c_forty_bit_io_expander_bench

// >>> shared/gpio_exp_pkg.sv
// types shared by the expander design
package gpio_exp_pkg;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_CMD   = 3'b010,
        ST_WDATA = 3'b011,
        ST_RDATA = 3'b100,
        ST_WAIT  = 3'b101
    } i2c_state_t;
endpackage : gpio_exp_pkg

// >>> shared/gpio_exp_regs.svh
// register map, reset values and addresses of the 40-line expander
`ifndef GPIO_EXP_REGS_SVH
`define GPIO_EXP_REGS_SVH
`define IO_W        40
`define NUM_BANKS   5
`define BANK_W      8
// register pointer = {group[2:0], bank[2:0]}
`define GRP_IN      3'h0
`define GRP_OUT     3'h1
`define GRP_POL     3'h2
`define GRP_DIR     3'h3
`define GRP_MASK    3'h4
`define GRP_OD      3'h5
`define GRP_MODE    3'h6
`define GRP_ID      3'h7
`define ID_IDX_MFR  3'h0
`define ID_IDX_PART 3'h1
`define ID_IDX_REV  3'h2
`define MODE_STOP   0
`define MODE_ALERT  1
`define RST_OUT     40'h00_0000_0000
`define RST_POL     40'h00_0000_0000
`define RST_DIR     40'hff_ffff_ffff
`define RST_MASK    40'h00_0000_0000
`define RST_OD      40'h00_0000_0000
`define RST_MODE    8'h00
`define RST_PTR     6'h00
`define TGT_BASE    7'h20
`define ALLCALL_ADR 7'h68
`define ARA_ADR     7'h0c
`define INIT_DONE   2'h3
`endif

// >>> src/gpio_expander.sv
// i2c target with forty configurable io lines in five banks
`timescale 1ns/100ps
`include "gpio_exp_regs.svh"
module gpio_expander #(
    // identity bytes: arbitrary values
    parameter logic [7:0] ID_MFR  = 8'h5a,
    parameter logic [7:0] ID_PART = 8'h3c,
    parameter logic [7:0] ID_REV  = 8'h01
) (
    // clock and reset
    input  wire logic                I_CLK,
    input  wire logic                I_RESET_N,
    // i2c bus
    input  wire logic                I_SCL,
    input  wire logic                I_SDA,
    output logic                     O_SDA_OE_N,
    // control pins
    input  wire logic                I_RST_PIN_N,
    input  wire logic                I_OE_N,
    input  wire logic [5:0]          I_ASEL,
    // io lines
    input  wire logic [`IO_W-1:0]    I_IO,
    output logic      [`IO_W-1:0]    O_IO,
    output logic      [`IO_W-1:0]    O_IO_OE_N,
    // open-drain flags
    output logic                     O_INT_OE_N,
    output logic                     O_ALERT_OE_N
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESET_N);

    ////////////////////////////////////////////////////////////////////////////
    logic [`IO_W+9:0]       sync_v;
    logic                   scl_s, sda_s, rstp_s, oe_dis_s;
    logic [5:0]             asel_s;
    logic [`IO_W-1:0]       in_s;

    gpio_sync2 #(.W(`IO_W + 10)) u_sync (
        .i_clk   (I_CLK),
        .i_rst_n (I_RESET_N),
        .i_d     ({I_SCL, I_SDA, I_RST_PIN_N, I_OE_N, I_ASEL, I_IO}),
        .o_q     (sync_v)
    );
    assign {scl_s, sda_s, rstp_s, oe_dis_s, asel_s, in_s} = sync_v;

    ////////////////////////////////////////////////////////////////////////////
    gpio_exp_pkg::i2c_state_t st_q, st_d;
    logic [3:0]             bit_q, bit_d;
    logic [7:0]             sh_q, sh_d;
    logic [5:0]             ptr_q, ptr_d;
    logic                   ack_q, ack_d, nack_q, nack_d, rw_q, rw_d, ara_q, ara_d;
    logic                   sda_oe_n_q, sda_oe_n_d, scl_p_q, sda_p_q;
    logic                   scl_rise, scl_fall, start_c, stop_c;
    logic                   wr_en, rd_load, stop_evt, ara_done;

    logic [`IO_W-1:0]       out_q, out_d, shad_q, shad_d, pol_q, pol_d, dir_q, dir_d;
    logic [`IO_W-1:0]       mask_q, mask_d, od_q, od_d, snap_q, snap_d, chg;
    logic [7:0]             mode_q, mode_d;
    logic [`NUM_BANKS-1:0]  pend_q, pend_d, chg_b, rd_clr;
    logic                   alert_q, alert_d, int_oe_n_q, alert_oe_n_q;
    logic [6:0]             own_q, own_d;
    logic [1:0]             init_q, init_d;

    function automatic logic bank_ok(input logic [2:0] b);
        bank_ok = (b < 3'(`NUM_BANKS));
    endfunction : bank_ok

    function automatic logic [7:0] bank_sl(input logic [`IO_W-1:0] v, input logic [2:0] b);
        bank_sl = v[b*`BANK_W +: `BANK_W];
    endfunction : bank_sl

    function automatic logic [`IO_W-1:0] wr_bank(input logic [`IO_W-1:0] v, input logic [2:0] b,
                                                  input logic [7:0] d);
        wr_bank = v;
        wr_bank[b*`BANK_W +: `BANK_W] = d;
    endfunction : wr_bank

    function automatic logic [7:0] rd_byte(input logic [5:0] p);
        rd_byte = 8'h00;
        if (p[5:3] == `GRP_ID) begin
            if (p[2:0] == `ID_IDX_MFR)  rd_byte = ID_MFR;
            if (p[2:0] == `ID_IDX_PART) rd_byte = ID_PART;
            if (p[2:0] == `ID_IDX_REV)  rd_byte = ID_REV;
        end else if (p[5:3] == `GRP_MODE) begin
            if (p[2:0] == 3'h0) rd_byte = mode_q;
        end else if (bank_ok(p[2:0])) begin
            unique case (p[5:3])
                `GRP_IN:   rd_byte = bank_sl(in_s ^ pol_q, p[2:0]);
                `GRP_OUT:  rd_byte = bank_sl(shad_q, p[2:0]);
                `GRP_POL:  rd_byte = bank_sl(pol_q, p[2:0]);
                `GRP_DIR:  rd_byte = bank_sl(dir_q, p[2:0]);
                `GRP_MASK: rd_byte = bank_sl(mask_q, p[2:0]);
                default:   rd_byte = bank_sl(od_q, p[2:0]);
            endcase
        end
    endfunction : rd_byte

    ////////////////////////////////////////////////////////////////////////////
    // bus engine: edges come from the synchronised copies only
    assign scl_rise = scl_s & ~scl_p_q;
    assign scl_fall = ~scl_s & scl_p_q;
    assign start_c  = scl_s & scl_p_q & ~sda_s & sda_p_q;
    assign stop_c   = scl_s & scl_p_q & sda_s & ~sda_p_q;

    always_comb begin
        st_d = st_q; bit_d = bit_q; sh_d = sh_q; ptr_d = ptr_q; ack_d = ack_q;
        nack_d = nack_q; rw_d = rw_q; ara_d = ara_q; sda_oe_n_d = sda_oe_n_q;
        wr_en = 1'b0; rd_load = 1'b0; stop_evt = 1'b0; ara_done = 1'b0;
        if (!rstp_s) begin
            st_d = gpio_exp_pkg::ST_IDLE; ack_d = 1'b0; sda_oe_n_d = 1'b1;
        end else if (start_c) begin
            st_d = gpio_exp_pkg::ST_ADDR; bit_d = 4'h0; ack_d = 1'b0; sda_oe_n_d = 1'b1;
        end else if (stop_c) begin
            st_d = gpio_exp_pkg::ST_IDLE; ack_d = 1'b0; sda_oe_n_d = 1'b1; stop_evt = 1'b1;
        end else if (scl_rise && st_q != gpio_exp_pkg::ST_IDLE && st_q != gpio_exp_pkg::ST_WAIT) begin
            if (ack_q) begin
                nack_d = sda_s;
            end else begin
                bit_d = 4'(bit_q + 4'h1);
                if (st_q != gpio_exp_pkg::ST_RDATA) sh_d = {sh_q[6:0], sda_s};
            end
        end else if (scl_fall && st_q != gpio_exp_pkg::ST_IDLE && st_q != gpio_exp_pkg::ST_WAIT) begin
            if (!ack_q && bit_q == 4'h8) begin
                ack_d = 1'b1; bit_d = 4'h0; sda_oe_n_d = 1'b1;
                unique case (st_q)
                    gpio_exp_pkg::ST_ADDR: begin
                        rw_d  = sh_q[0];
                        ara_d = (sh_q[7:1] == `ARA_ADR) && sh_q[0] && alert_q;
                        if (sh_q[7:1] == own_q || ara_d) sda_oe_n_d = 1'b0;
                        else if (sh_q[7:1] == `ALLCALL_ADR && !sh_q[0]) sda_oe_n_d = 1'b0;
                        else st_d = gpio_exp_pkg::ST_WAIT;
                    end
                    gpio_exp_pkg::ST_CMD: begin
                        ptr_d = sh_q[5:0]; sda_oe_n_d = 1'b0;
                    end
                    gpio_exp_pkg::ST_WDATA: begin
                        wr_en = 1'b1; ptr_d = ptr_q + 6'h01; sda_oe_n_d = 1'b0;
                    end
                    gpio_exp_pkg::ST_RDATA: ;
                    default: st_d = gpio_exp_pkg::ST_WAIT;
                endcase
            end else if (ack_q) begin
                ack_d = 1'b0; sda_oe_n_d = 1'b1;
                if (st_q == gpio_exp_pkg::ST_ADDR)
                    st_d = rw_q ? gpio_exp_pkg::ST_RDATA : gpio_exp_pkg::ST_CMD;
                else if (st_q == gpio_exp_pkg::ST_CMD) st_d = gpio_exp_pkg::ST_WDATA;
                else if (st_q == gpio_exp_pkg::ST_RDATA && nack_q) st_d = gpio_exp_pkg::ST_WAIT;
                if (st_d == gpio_exp_pkg::ST_RDATA) begin
                    sh_d = ara_q ? {own_q, 1'b0} : rd_byte(ptr_q);
                    sda_oe_n_d = sh_d[7];
                    rd_load = ~ara_q;
                    ara_done = ara_q;
                    if (!ara_q) ptr_d = ptr_q + 6'h01;
                end
            end else if (st_q == gpio_exp_pkg::ST_RDATA) begin
                sh_d = {sh_q[6:0], 1'b0};
                sda_oe_n_d = sh_d[7];
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            st_q <= gpio_exp_pkg::ST_IDLE; bit_q <= 4'h0; sh_q <= 8'h00; ptr_q <= `RST_PTR;
            ack_q <= 1'b0; nack_q <= 1'b0; rw_q <= 1'b0; ara_q <= 1'b0;
            sda_oe_n_q <= 1'b1; scl_p_q <= 1'b1; sda_p_q <= 1'b1;
        end else begin
            st_q <= st_d; bit_q <= bit_d; sh_q <= sh_d; ptr_q <= ptr_d;
            ack_q <= ack_d; nack_q <= nack_d; rw_q <= rw_d; ara_q <= ara_d;
            sda_oe_n_q <= sda_oe_n_d; scl_p_q <= scl_s; sda_p_q <= sda_s;
        end
    end
    assign O_SDA_OE_N = sda_oe_n_q;

    ////////////////////////////////////////////////////////////////////////////
    // change detection against the value last read, per bank
    assign chg = (in_s ^ snap_q) & ~mask_q & dir_q;

    always_comb begin
        out_d = out_q; shad_d = shad_q; pol_d = pol_q; dir_d = dir_q; mask_d = mask_q;
        od_d = od_q; mode_d = mode_q; snap_d = snap_q; own_d = own_q; init_d = init_q;
        rd_clr = '0;
        if (rd_load && ptr_q[5:3] == `GRP_IN && bank_ok(ptr_q[2:0]))
            rd_clr[ptr_q[2:0]] = 1'b1;
        // a change that coincides with the read is inside the read value itself
        pend_d  = (pend_q | chg_b) & ~rd_clr;
        alert_d = (alert_q & ~ara_done) | (mode_q[`MODE_ALERT] & |(chg_b & ~pend_q & ~rd_clr));
        for (int b = 0; b < `NUM_BANKS; b++)
            if (rd_clr[b]) snap_d[b*`BANK_W +: `BANK_W] = in_s[b*`BANK_W +: `BANK_W];
        if (wr_en && ptr_q[5:3] == `GRP_MODE && ptr_q[2:0] == 3'h0) mode_d = sh_q;
        if (wr_en && bank_ok(ptr_q[2:0])) begin
            unique case (ptr_q[5:3])
                `GRP_OUT: begin
                    shad_d = wr_bank(shad_q, ptr_q[2:0], sh_q);
                    if (!mode_q[`MODE_STOP]) out_d = wr_bank(out_q, ptr_q[2:0], sh_q);
                end
                `GRP_POL:  pol_d  = wr_bank(pol_q, ptr_q[2:0], sh_q);
                `GRP_DIR:  dir_d  = wr_bank(dir_q, ptr_q[2:0], sh_q);
                `GRP_MASK: mask_d = wr_bank(mask_q, ptr_q[2:0], sh_q);
                `GRP_OD:   od_d   = wr_bank(od_q, ptr_q[2:0], sh_q);
                default: ;
            endcase
        end
        if (stop_evt && mode_q[`MODE_STOP]) out_d = shad_q;
        // straps and the input baseline are caught once the synchronisers have filled
        if (init_q != `INIT_DONE) begin
            init_d = 2'(init_q + 2'h1);
            own_d  = `TGT_BASE + 7'(asel_s);
            snap_d = in_s;
            pend_d = '0;
            alert_d = 1'b0;
        end
        if (!rstp_s) begin
            out_d = `RST_OUT; shad_d = `RST_OUT; pol_d = `RST_POL; dir_d = `RST_DIR;
            mask_d = `RST_MASK; od_d = `RST_OD; mode_d = `RST_MODE; snap_d = in_s;
            pend_d = '0; alert_d = 1'b0;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            out_q <= `RST_OUT; shad_q <= `RST_OUT; pol_q <= `RST_POL; dir_q <= `RST_DIR;
            mask_q <= `RST_MASK; od_q <= `RST_OD; mode_q <= `RST_MODE; snap_q <= '0;
            pend_q <= '0; alert_q <= 1'b0; own_q <= `TGT_BASE; init_q <= 2'h0;
            int_oe_n_q <= 1'b1; alert_oe_n_q <= 1'b1;
        end else begin
            out_q <= out_d; shad_q <= shad_d; pol_q <= pol_d; dir_q <= dir_d;
            mask_q <= mask_d; od_q <= od_d; mode_q <= mode_d; snap_q <= snap_d;
            pend_q <= pend_d; alert_q <= alert_d; own_q <= own_d; init_q <= init_d;
            int_oe_n_q <= ~|pend_q;
            alert_oe_n_q <= ~alert_q;
        end
    end
    assign O_INT_OE_N   = int_oe_n_q;
    assign O_ALERT_OE_N = alert_oe_n_q;

    ////////////////////////////////////////////////////////////////////////////
    for (genvar g = 0; g < `NUM_BANKS; g++) begin : g_bank
        assign chg_b[g] = |chg[g*`BANK_W +: `BANK_W];
        gpio_io_bank #(.W(`BANK_W)) u_bank (
            .i_clk   (I_CLK),
            .i_rst_n (I_RESET_N),
            .i_out   (out_q[g*`BANK_W +: `BANK_W]),
            .i_dir   (dir_q[g*`BANK_W +: `BANK_W]),
            .i_od    (od_q[g*`BANK_W +: `BANK_W]),
            .i_oe_ok (~oe_dis_s),
            .o_pin   (O_IO[g*`BANK_W +: `BANK_W]),
            .o_oe_n  (O_IO_OE_N[g*`BANK_W +: `BANK_W])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // a fresh alert event in the response cycle keeps the alert raised
    logic                   alert_new;
    assign alert_new = mode_q[`MODE_ALERT] & |(chg_b & ~pend_q & ~rd_clr);

    sequence s_stop_commit;
        stop_evt && mode_q[`MODE_STOP] && rstp_s;
    endsequence
    sequence s_ack_write;
        wr_en && ptr_q[5:3] == `GRP_OUT && bank_ok(ptr_q[2:0]) && !mode_q[`MODE_STOP] && rstp_s;
    endsequence

    property p_rst_dir;
        !rstp_s |=> dir_q == `RST_DIR && O_SDA_OE_N;
    endproperty
    a_rst_dir: assert property (p_rst_dir) else $error("reset pin left a line as output");
    property p_upd_ack;
        s_ack_write |=> bank_sl(out_q, $past(ptr_q[2:0])) == $past(sh_q);
    endproperty
    a_upd_ack: assert property (p_upd_ack) else $error("bank not updated at acknowledge");
    property p_upd_stop;
        s_stop_commit |=> out_q == $past(shad_q);
    endproperty
    a_upd_stop: assert property (p_upd_stop) else $error("outputs not committed at stop");
    property p_int_set;
        (|(chg_b & ~rd_clr)) && rstp_s && init_q == `INIT_DONE |=> pend_q != '0 ##1 !O_INT_OE_N;
    endproperty
    a_int_set: assert property (p_int_set) else $error("change did not raise interrupt");
    property p_mask;
        pend_q == '0 && chg_b == '0 && ((in_s ^ snap_q) & dir_q & mask_q) != '0 |=> pend_q == '0;
    endproperty
    a_mask: assert property (p_mask) else $error("masked line raised interrupt");
    property p_clear;
        rd_clr != '0 && rstp_s |=> (pend_q & $past(rd_clr)) == '0;
    endproperty
    a_clear: assert property (p_clear) else $error("read did not clear bank interrupt");
    property p_inv;
        rd_load && ptr_q[5:3] == `GRP_IN && bank_ok(ptr_q[2:0])
            |=> sh_q == bank_sl($past(in_s) ^ $past(pol_q), $past(ptr_q[2:0]));
    endproperty
    a_inv: assert property (p_inv) else $error("input read ignored inversion");
    property p_allcall;
        scl_fall && rstp_s && st_q == gpio_exp_pkg::ST_ADDR && !ack_q && bit_q == 4'h8
            && sh_q == {`ALLCALL_ADR, 1'b0} |=> !O_SDA_OE_N && ack_q;
    endproperty
    a_allcall: assert property (p_allcall) else $error("all-call not acknowledged");
    property p_alert;
        ara_done |=> alert_q == $past(alert_new) ##1 O_ALERT_OE_N == !$past(alert_q);
    endproperty
    a_alert: assert property (p_alert) else $error("alert not released after response");
    property p_addr;
        init_q == 2'h2 && rstp_s |=> own_q == `TGT_BASE + 7'($past(asel_s));
    endproperty
    a_addr: assert property (p_addr) else $error("target address not taken from select pins");
endmodule : gpio_expander

// >>> src/gpio_io_bank.sv
// pad drive of one bank of eight lines
`timescale 1ns/100ps
module gpio_io_bank #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    // configuration
    input  wire logic [W-1:0] i_out,
    input  wire logic [W-1:0] i_dir,
    input  wire logic [W-1:0] i_od,
    input  wire logic         i_oe_ok,
    // pad
    output logic      [W-1:0] o_pin,
    output logic      [W-1:0] o_oe_n
);
    logic [W-1:0] pin_d;
    logic [W-1:0] oe_n_d;

    always_comb begin
        // open-drain lines only ever pull low, so their data stays 0
        pin_d  = i_out & ~i_od;
        oe_n_d = i_oe_ok ? (i_dir | (i_od & i_out)) : '1;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pin  <= '0;
            o_oe_n <= '1;
        end else begin
            o_pin  <= pin_d;
            o_oe_n <= oe_n_d;
        end
    end

    property p_drive;
        @(posedge i_clk) disable iff (!i_rst_n)
        1'b1 |=> (o_oe_n == ($past(i_oe_ok) ? ($past(i_dir) | ($past(i_od) & $past(i_out))) : {W{1'b1}}))
            && (o_pin == ($past(i_out) & ~$past(i_od)));
    endproperty
    a_drive: assert property (p_drive) else $error("bank drive mismatch");

    property p_oe_off;
        @(posedge i_clk) disable iff (!i_rst_n)
        !i_oe_ok |=> &o_oe_n;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("output not released while disabled");
endmodule : gpio_io_bank

// >>> src/gpio_sync2.sv
// two-flop synchroniser for pins entering the core clock domain
`timescale 1ns/100ps
module gpio_sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    // data
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta_q;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= '0;
            o_q    <= '0;
        end else begin
            meta_q <= i_d;
            o_q    <= meta_q;
        end
    end
endmodule : gpio_sync2
